/* File: bench/ocdhc_probe.sv */
// Behavioural debug probe driving the link side.
`timescale 1ns/1ps
module ocdhc_probe
	import ocdhc_pkg::*;
(
	output logic         dbg_clk,   // Link clock, still between frames.
	output logic         cmd_valid, // Command strobe.
	output logic [2:0]   cmd_op,    // Command code.
	output ocdhc_bpcfg_t cmd_bpcfg  // Breakpoint setup.
);
	initial
	begin
		dbg_clk = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 3'h0;
		cmd_bpcfg = '0;
	end
	task automatic tick(input int n);
		repeat (n)
		begin
			#7.5 dbg_clk = 1'b1;
			#7.5 dbg_clk = 1'b0;
		end
	endtask : tick
	// The probe's OCDHC_CMD_RDMSG poll of the message byte also clears the msg_fresh flag.
	task automatic send(input logic [2:0] op, input ocdhc_bpcfg_t c);
		cmd_op = op;
		cmd_bpcfg = c;
		cmd_valid = 1'b1;
		tick(1);
		cmd_valid = 1'b0;
		cmd_op = ~op;
		cmd_bpcfg = ~c;
		tick(4);
	endtask : send
endmodule : ocdhc_probe

/* File: bench/ocdhc_props.sv */
// Port checks for the debug halt control block.
`timescale 1ns/1ps
module ocdhc_props
	import ocdhc_pkg::*;
(
	input wire logic clk,                     // Core clock.
	input wire logic srst,                    // Sync reset.
	input wire logic newer_family,            // Family strap.
	input wire logic link_is_two_wire,        // Two-wire link.
	input wire logic debug_unit_enable_fuse,  // Debug fuse.
	input wire logic scan_port_disable_bit,   // Firmware disable.
	input wire logic timer_freeze_cfg,        // Timer freeze choice.
	input wire logic debug_unit_halted,       // Core stopped.
	input wire logic cpu_clk_sel_dbg,         // Debug clock select.
	input wire logic periph_run_en,           // Peripherals run.
	input wire logic timer_run_en,            // Timers run.
	input wire logic watchdog_run_en,         // Watchdog runs.
	input wire logic scan_port_active,        // Scan port on.
	input wire logic scan_pins_alt_en,        // Alternate functions.
	input wire logic debug_access_en,         // Debug reachable.
	input wire logic two_wire_clk_from_reset  // Reset pin clocks link.
);
	// ====
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	property p_wdog;
		watchdog_run_en == !debug_unit_halted;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog run wrong");
	property p_alt;
		scan_pins_alt_en == !scan_port_active;
	endproperty
	a_alt: assert property (p_alt) else $error("scan pins shared");
	property p_acc;
		!debug_unit_enable_fuse [*4] |-> !debug_access_en;
	endproperty
	a_acc: assert property (p_acc) else $error("access without fuse");
	property p_dis;
		scan_port_disable_bit [*4] |-> !scan_port_active;
	endproperty
	a_dis: assert property (p_dis) else $error("scan port not disabled");
	property p_csel;
		newer_family [*4] |-> cpu_clk_sel_dbg == debug_unit_halted;
	endproperty
	a_csel: assert property (p_csel) else $error("clock select wrong");
	property p_new;
		$rose(debug_unit_halted) && newer_family |-> !periph_run_en && !timer_run_en;
	endproperty
	a_new: assert property (p_new) else $error("newer family not frozen");
	property p_tmr;
		(debug_unit_halted && timer_freeze_cfg) [*4] |-> !timer_run_en;
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer not frozen");
	property p_old;
		!newer_family [*4] |-> periph_run_en;
	endproperty
	a_old: assert property (p_old) else $error("older family stopped");
	property p_tw;
		!link_is_two_wire [*4] |-> !two_wire_clk_from_reset;
	endproperty
	a_tw: assert property (p_tw) else $error("reset pin clocks link");
endmodule : ocdhc_props
bind ocdhc_top ocdhc_props props_u (.clk(clk), .srst(srst), .newer_family(newer_family),
	.link_is_two_wire(link_is_two_wire), .debug_unit_enable_fuse(debug_unit_enable_fuse),
	.scan_port_disable_bit(scan_port_disable_bit), .timer_freeze_cfg(timer_freeze_cfg),
	.debug_unit_halted(debug_unit_halted), .cpu_clk_sel_dbg(cpu_clk_sel_dbg),
	.periph_run_en(periph_run_en), .timer_run_en(timer_run_en), .watchdog_run_en(watchdog_run_en),
	.scan_port_active(scan_port_active), .scan_pins_alt_en(scan_pins_alt_en),
	.debug_access_en(debug_access_en), .two_wire_clk_from_reset(two_wire_clk_from_reset));

/* File: bench/tb_on_chip_debug_halt_control.sv */
// Testbench for the debug halt control block.
`timescale 1ns/1ps
`include "ocdhc_consts.svh"
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin miscompares++; \
$display("unexpected %s: expected %0h, seen %0h", n, e, a); end end
module tb_on_chip_debug_halt_control;
	import ocdhc_pkg::*;
	logic clk = 1'b0, srst = 1'b1, newer = 1'b0, two_w = 1'b0, sfuse = 1'b1;
	logic dfuse = 1'b0, sdis = 1'b0, tfz = 1'b0, mwr = 1'b0;
	logic [7:0] mdat = 8'h00;
	ocdhc_bus_t bus = '0;
	logic dclk, cv, hlt, csel, prun, trun, wrun, sact, alt, acc, twr, fresh;
	logic [2:0] cop;
	ocdhc_bpcfg_t cbp, bp;
	logic [7:0] msg;
	int checked = 0, miscompares = 0, cycles = 0;
	ocdhc_top dut_u (.clk(clk), .srst(srst), .dbg_clk(dclk), .newer_family(newer),
		.link_is_two_wire(two_w), .scan_port_enable_fuse(sfuse), .debug_unit_enable_fuse(dfuse),
		.scan_port_disable_bit(sdis), .timer_freeze_cfg(tfz), .msg_wr(mwr), .msg_wdata(mdat),
		.core_bus(bus), .cmd_valid(cv), .cmd_op(cop), .cmd_bpcfg(cbp), .debug_unit_halted(hlt),
		.cpu_clk_sel_dbg(csel), .periph_run_en(prun), .timer_run_en(trun), .watchdog_run_en(wrun),
		.scan_port_active(sact), .scan_pins_alt_en(alt), .debug_access_en(acc),
		.two_wire_clk_from_reset(twr), .debug_message_register(msg), .msg_fresh(fresh));
	ocdhc_probe probe_u (.dbg_clk(dclk), .cmd_valid(cv), .cmd_op(cop), .cmd_bpcfg(cbp));
	always #50 clk = ~clk;
	// ====
	// Shared steps
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic cmd(input logic [2:0] op);
		probe_u.send(op, bp);
		cyc(8);
	endtask : cmd
	task automatic give_verdict();
		$display("%0d checked, %0d miscompares", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			give_verdict();
		end
	end
	// ====
	// Scenarios
	task automatic t_gate();
		cmd(`OCDHC_CMD_HALT);
		`CHK("sact", 1'b1, sact)
		`CHK("alt", 1'b0, alt)
		`CHK("acc", 1'b0, acc)
		`CHK("refused halt", 1'b0, hlt)
		sdis = 1'b1;
		cyc(5);
		`CHK("sact off", 1'b0, sact)
		`CHK("alt on", 1'b1, alt)
		two_w = 1'b1;
		dfuse = 1'b1;
		cyc(5);
		`CHK("acc", 1'b1, acc)
		`CHK("twr", 1'b1, twr)
		two_w = 1'b0;
		sdis = 1'b0;
		cyc(5);
		$display("gate test done");
	endtask : t_gate
	task automatic t_old();
		for (int i = 0; i < 2; i++)
		begin
			tfz = i[0];
			cmd(`OCDHC_CMD_HALT);
			`CHK("halted", 1'b1, hlt)
			`CHK("prun", 1'b1, prun)
			`CHK("wrun", 1'b0, wrun)
			`CHK("trun", ~i[0], trun)
			`CHK("csel", 1'b0, csel)
			cmd(`OCDHC_CMD_RUN);
			`CHK("wrun back", 1'b1, wrun)
		end
		$display("older family test done");
	endtask : t_old
	task automatic t_msg();
		mdat = 8'h11;
		mwr = 1'b1;
		cyc(1);
		mdat = 8'h5a;
		cyc(1);
		mwr = 1'b0;
		cyc(2);
		probe_u.tick(8);
		`CHK("msg", 8'h5a, msg)
		`CHK("fresh", 1'b1, fresh)
		cmd(`OCDHC_CMD_RDMSG);
		`CHK("fresh read", 1'b0, fresh)
		$display("message test done");
	endtask : t_msg
	task automatic t_bp(input ocdhc_bpmode_t m, input logic d, input logic [15:0] miss, hit);
		bp = '0;
		bp.mode = m;
		bp.is_data = d;
		bp.use_arng = d;
		bp.addr0 = 16'h0100;
		bp.addr1 = 16'h01ff;
		bp.val0 = 8'h3c;
		cmd(`OCDHC_CMD_BPCFG);
		bus = '{1'b1, d, miss, 8'h3c};
		cyc(4);
		`CHK("bp miss", 1'b0, hlt)
		bus.addr = hit;
		cyc(1);
		bus.valid = 1'b0;
		cyc(4);
		`CHK("bp halt", 1'b1, hlt)
		bp = '0;
		cmd(`OCDHC_CMD_BPCFG);
		cmd(`OCDHC_CMD_RUN);
		$display("breakpoint test done");
	endtask : t_bp
	task automatic t_new();
		cmd(`OCDHC_CMD_HALT);
		`CHK("prun new", 1'b0, prun)
		`CHK("trun new", 1'b0, trun)
		`CHK("csel new", 1'b1, csel)
		cmd(`OCDHC_CMD_STEP);
		`CHK("step halt", 1'b1, hlt)
		cmd(`OCDHC_CMD_RUN);
		`CHK("csel run", 1'b0, csel)
		$display("newer family test done");
	endtask : t_new
	initial
	begin
		bp = '0;
		probe_u.tick(4);
		cyc(3);
		srst = 1'b0;
		probe_u.tick(4);
		cyc(5);
		cmd(`OCDHC_CMD_RDMSG);
		t_gate();
		t_old();
		t_msg();
		t_bp(OCDHC_BP_TWO, 1'b0, 16'h0150, 16'h01ff);
		t_bp(OCDHC_BP_DRNG, 1'b1, 16'h0200, 16'h01ff);
		t_bp(OCDHC_BP_RANGE, 1'b0, 16'h0200, 16'h0150);
		t_bp(OCDHC_BP_TWOV, 1'b1, 16'h0150, 16'h0100);
		srst = 1'b1;
		newer = 1'b1;
		probe_u.tick(4);
		cyc(3);
		srst = 1'b0;
		probe_u.tick(4);
		cyc(5);
		t_new();
		dfuse = 1'b0;
		give_verdict();
	end
endmodule : tb_on_chip_debug_halt_control

/* File: hdl/ocdhc_bp_match.sv */
// Four-comparator hardware breakpoint matcher.
`timescale 1ns/1ps
`include "ocdhc_consts.svh"
module ocdhc_bp_match
	import ocdhc_pkg::*;
(
	input  wire logic         clk,    // Core clock.
	input  wire logic         srst,   // Synchronous reset.
	input  wire ocdhc_bpcfg_t cfg,    // Comparator setup.
	input  wire ocdhc_bus_t   bus,    // Observed access.
	output logic              hit     // Registered breakpoint hit.
);
	function automatic logic in_rng(input logic [15:0] x, input logic [15:0] lo, input logic [15:0] hi);
		in_rng = (x >= lo) && (x <= hi);
	endfunction : in_rng

	logic m;
	logic vmatch;

	always_comb
	begin
		vmatch = cfg.use_vrng ? in_rng({8'h00, bus.value}, {8'h00, cfg.val0}, {8'h00, cfg.val1})
		                      : (bus.value == cfg.val0);
		m = 1'b0;
		// One access type for all comparators; mode limits the set.
		if (bus.valid && (bus.is_data == cfg.is_data))
		begin
			case (cfg.mode)
				OCDHC_BP_TWO:   m = (bus.addr == cfg.addr0) || (bus.addr == cfg.addr1);
				OCDHC_BP_RANGE: m = in_rng(bus.addr, cfg.addr0, cfg.addr1);
				OCDHC_BP_TWOV:  m = cfg.is_data && ((bus.addr == cfg.addr0) || (bus.addr == cfg.addr1)) && vmatch;
				OCDHC_BP_DRNG:  m = cfg.is_data
					&& (cfg.use_arng ? in_rng(bus.addr, cfg.addr0, cfg.addr1) : (bus.addr == cfg.addr0))
					&& (cfg.use_vrng ? vmatch : 1'b1);
				default:        m = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			hit <= 1'b0;
		else
			hit <= m;
	end
endmodule : ocdhc_bp_match

/* File: hdl/ocdhc_consts.svh */
// Constants for the on-chip debug halt control block.
`ifndef OCDHC_CONSTS_SVH
`define OCDHC_CONSTS_SVH
`define OCDHC_AW            16
`define OCDHC_DW            8
`define OCDHC_MSG_RESET     8'h00
`define OCDHC_POLL_MS       50
`define OCDHC_CLK_HZ        10000000
`define OCDHC_POLL_CYC      ((`OCDHC_POLL_MS * `OCDHC_CLK_HZ) / 1000)
`define OCDHC_STRAP_WAIT    2'h2
`define OCDHC_CMD_RUN       3'h1
`define OCDHC_CMD_STEP      3'h2
`define OCDHC_CMD_HALT      3'h3
`define OCDHC_CMD_RDMSG     3'h4
`define OCDHC_CMD_BPCFG     3'h5
`endif

/* File: hdl/ocdhc_pkg.sv */
// Types shared by the debug halt control block.
package ocdhc_pkg;
	typedef enum logic [2:0]
	{
		OCDHC_BP_OFF   = 3'h0,
		OCDHC_BP_TWO   = 3'h1,
		OCDHC_BP_RANGE = 3'h2,
		OCDHC_BP_TWOV  = 3'h3,
		OCDHC_BP_DRNG  = 3'h4
	} ocdhc_bpmode_t;

	typedef struct packed
	{
		logic [15:0] addr0;
		logic [15:0] addr1;
		logic [7:0]  val0;
		logic [7:0]  val1;
		logic        is_data;
		logic        use_arng;
		logic        use_vrng;
		ocdhc_bpmode_t mode;
	} ocdhc_bpcfg_t;

	typedef struct packed
	{
		logic        valid;
		logic        is_data;
		logic [15:0] addr;
		logic [7:0]  value;
	} ocdhc_bus_t;

	typedef enum logic [2:0]
	{
		OCDHC_ST_RUN  = 3'b001,
		OCDHC_ST_STOP = 3'b010,
		OCDHC_ST_STEP = 3'b100
	} ocdhc_state_t;
endpackage : ocdhc_pkg

/* File: hdl/ocdhc_top.sv */
// On-chip debug halt control: freezes, scan port gating, message byte, breakpoints.
// Summary of operation
// - Older family keeps peripherals running while halted.
// - Debug setting chooses timer freeze when halted, in the older family.
// - Watchdog always frozen while halted.
// - Wide registers move as two byte accesses.
// - Scan port from fuse; debug needs fuse.
// - Firmware disable bit turns scan port off.
// - Enabled scan pins have no alternate functions.
// - Program message byte polled by probe.
// - Newer family runs from debug clock halted.
// - Newer family halts all peripherals halted.
// - Four breakpoint comparators, two address, two value.
// - All breakpoints share one type and area.
// - Supported comparator combinations only.
// - Two-wire link clocked from reset pin; the code does so only while the debug unit fuse is programmed.
`timescale 1ns/1ps
`include "ocdhc_consts.svh"
module ocdhc_top
	import ocdhc_pkg::*;
(
	input  wire logic         clk,                    // Core clock, 10 MHz.
	input  wire logic         srst,                   // Synchronous reset.
	input  wire logic         dbg_clk,                // Debug link clock (scan or reset pin).
	input  wire logic         newer_family,           // Strap: newer core family.
	input  wire logic         link_is_two_wire,       // Link uses reset pin as clock.
	input  wire logic         scan_port_enable_fuse,  // Scan port fuse, programmed.
	input  wire logic         debug_unit_enable_fuse, // Debug unit fuse, programmed.
	input  wire logic         scan_port_disable_bit,  // Firmware scan disable.
	input  wire logic         timer_freeze_cfg,       // Debugger timer freeze choice.
	input  wire logic         msg_wr,                 // Program writes message byte.
	input  wire logic [7:0]   msg_wdata,              // Message byte from program.
	input  wire ocdhc_bus_t   core_bus,               // Core access for breakpoints.
	input  wire logic         cmd_valid,              // Probe command strobe, link domain.
	input  wire logic [2:0]   cmd_op,                 // Probe command code.
	input  wire ocdhc_bpcfg_t cmd_bpcfg,              // Breakpoint setup from probe.
	output logic              debug_unit_halted,      // Core stopped.
	output logic              cpu_clk_sel_dbg,        // Select debug clock for MCU.
	output logic              periph_run_en,          // General peripherals run.
	output logic              timer_run_en,           // Timers run.
	output logic              watchdog_run_en,        // Watchdog runs.
	output logic              scan_port_active,       // Scan port owns its pins.
	output logic              scan_pins_alt_en,       // Alternate pin functions allowed.
	output logic              debug_access_en,        // Debug unit reachable.
	output logic              two_wire_clk_from_reset,// Reset pin acts as link clock.
	output logic [7:0]        debug_message_register, // Message byte to probe, link domain.
	output logic              msg_fresh               // Unread message flag, link domain.
);
	// ==================================================================
	// Link-domain command capture and crossing
	// ==================================================================
	logic [2:0]   op_l_q;
	logic         tgl_l_q;
	ocdhc_bpcfg_t bpcfg_l_q;
	logic [1:0]   rst_l_q;
	logic         rst_l;

	// Reset reaches the link side only while the probe clocks it, so the probe must tick during reset.
	always_ff @(posedge dbg_clk)
	begin
		rst_l_q <= {rst_l_q[0], srst};
	end
	assign rst_l = rst_l_q[1];

	// Link clock only runs during transactions; a toggle carries each command.
	always_ff @(posedge dbg_clk)
	begin
		if (rst_l)
		begin
			op_l_q    <= 3'h0;
			bpcfg_l_q <= '0;
			tgl_l_q   <= 1'b0;
		end
		else if (cmd_valid)
		begin
			op_l_q    <= cmd_op;
			bpcfg_l_q <= cmd_bpcfg;
			tgl_l_q   <= ~tgl_l_q;
		end
	end

	logic [2:0] tgl_s_q;
	logic       cmd_evt;
	always_ff @(posedge clk)
	begin
		if (srst)
			tgl_s_q <= 3'h0;
		else
			tgl_s_q <= {tgl_s_q[1:0], tgl_l_q};
	end
	assign cmd_evt = tgl_s_q[2] ^ tgl_s_q[1];

	// Command words are stable for many core cycles once the toggle arrives.
	logic [2:0]   op_c;
	ocdhc_bpcfg_t bpcfg_c;
	assign op_c    = op_l_q;
	assign bpcfg_c = bpcfg_l_q;

	// ==================================================================
	// Pin and fuse synchronisers
	// ==================================================================
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pin_s1_q <= 6'h00;
			pin_s2_q <= 6'h00;
		end
		else
		begin
			pin_s1_q <= {newer_family, link_is_two_wire, scan_port_enable_fuse,
			             debug_unit_enable_fuse, scan_port_disable_bit, timer_freeze_cfg};
			pin_s2_q <= pin_s1_q;
		end
	end

	// The synchroniser still shows its reset value for two edges, so the strap is taken after that.
	logic       newer_q;
	logic       strap_seen_q;
	logic [1:0] strap_wait_q;
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			newer_q      <= 1'b0;
			strap_seen_q <= 1'b0;
			strap_wait_q <= 2'h0;
		end
		else if (strap_wait_q != `OCDHC_STRAP_WAIT)
			strap_wait_q <= strap_wait_q + 2'h1;
		else if (!strap_seen_q)
		begin
			newer_q      <= pin_s2_q[5];
			strap_seen_q <= 1'b1;
		end
	end

	// ==================================================================
	// Scan port and debug access gating
	// ==================================================================
	logic scan_on;
	assign scan_on = pin_s2_q[3] && !pin_s2_q[1];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scan_port_active <= 1'b0;
			scan_pins_alt_en <= 1'b1;
			debug_access_en  <= 1'b0;
		end
		else
		begin
			scan_port_active <= scan_on;
			scan_pins_alt_en <= !scan_on;
			debug_access_en  <= (scan_on || pin_s2_q[4]) && pin_s2_q[2];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			two_wire_clk_from_reset <= 1'b0;
		else
			two_wire_clk_from_reset <= pin_s2_q[4] && pin_s2_q[2];
	end

	// ==================================================================
	// Breakpoint setup and matching
	// ==================================================================
	ocdhc_bpcfg_t bpcfg_q;
	always_ff @(posedge clk)
	begin
		if (srst)
			bpcfg_q <= '0;
		else if (cmd_evt && (op_c == `OCDHC_CMD_BPCFG) && debug_access_en)
			bpcfg_q <= bpcfg_c;
	end

	logic bp_hit;
	ocdhc_bp_match u_bp
	(
		.clk  (clk),
		.srst (srst),
		.cfg  (bpcfg_q),
		.bus  (core_bus),
		.hit  (bp_hit)
	);

	// ==================================================================
	// Run / stop / step control
	// ==================================================================
	ocdhc_state_t st_q;
	always_ff @(posedge clk)
	begin
		if (srst)
			st_q <= OCDHC_ST_RUN;
		else if (!debug_access_en)
			st_q <= OCDHC_ST_RUN;
		else
		begin
			case (st_q)
				OCDHC_ST_RUN:
				begin
					if (bp_hit || (cmd_evt && op_c == `OCDHC_CMD_HALT))
						st_q <= OCDHC_ST_STOP;
				end
				OCDHC_ST_STOP:
				begin
					if (cmd_evt && op_c == `OCDHC_CMD_RUN)
						st_q <= OCDHC_ST_RUN;
					else if (cmd_evt && op_c == `OCDHC_CMD_STEP)
						st_q <= OCDHC_ST_STEP;
				end
				OCDHC_ST_STEP:
					st_q <= OCDHC_ST_STOP;
				default:
					st_q <= OCDHC_ST_RUN;
			endcase
		end
	end

	logic halted;
	assign halted = (st_q == OCDHC_ST_STOP);

	// ==================================================================
	// Peripheral freeze controls
	// ==================================================================
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			debug_unit_halted <= 1'b0;
			cpu_clk_sel_dbg   <= 1'b0;
			periph_run_en     <= 1'b1;
			timer_run_en      <= 1'b1;
			watchdog_run_en   <= 1'b1;
		end
		else
		begin
			debug_unit_halted <= halted;
			cpu_clk_sel_dbg   <= halted && newer_q;
			periph_run_en     <= !(halted && newer_q);
			timer_run_en      <= !(halted && (newer_q || pin_s2_q[0]));
			watchdog_run_en   <= !halted;
		end
	end

	// ==================================================================
	// Debug message byte
	// ==================================================================
	// Core-side holding byte; a later write before the poll overwrites it.
	// A toggle is only sent once the link side has taken the last one, so two quick writes
	// cannot cancel out; a write landing just after the link takes a byte may be lost.
	logic [7:0] msg_c_q;
	logic       msg_tgl_c_q;
	logic [2:0] msg_tgl_l_q;
	logic [1:0] msg_ack_s_q;
	always_ff @(posedge clk)
	begin
		if (srst)
			msg_ack_s_q <= 2'h0;
		else
			msg_ack_s_q <= {msg_ack_s_q[0], msg_tgl_l_q[2]};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			msg_c_q     <= `OCDHC_MSG_RESET;
			msg_tgl_c_q <= 1'b0;
		end
		else if (msg_wr && !halted)
		begin
			msg_c_q <= msg_wdata;
			if (msg_tgl_c_q == msg_ack_s_q[1])
				msg_tgl_c_q <= ~msg_tgl_c_q;
		end
	end

	logic msg_rd;
	assign msg_rd = cmd_valid && (cmd_op == `OCDHC_CMD_RDMSG);

	// New byte sets fresh; a poll read clears it unless a byte lands together.
	always_ff @(posedge dbg_clk)
	begin
		if (rst_l)
		begin
			msg_tgl_l_q            <= 3'h0;
			debug_message_register <= `OCDHC_MSG_RESET;
			msg_fresh              <= 1'b0;
		end
		else
		begin
			msg_tgl_l_q <= {msg_tgl_l_q[1:0], msg_tgl_c_q};
			if (msg_tgl_l_q[2] ^ msg_tgl_l_q[1])
			begin
				debug_message_register <= msg_c_q;
				msg_fresh              <= 1'b1;
			end
			else if (msg_rd)
				msg_fresh <= 1'b0;
		end
	end
endmodule : ocdhc_top
